// file: pkg/dram_refresh_pkg.sv
// constants for the dram refresh and bank control block
`default_nettype none

package dram_refresh_pkg;

  // ********************************
  // register byte offsets
  // ********************************
  localparam logic [7:0] MEM_CTRL_OFS  = 8'h00;
  localparam logic [7:0] RT_CSR_OFS    = 8'h04;
  localparam logic [7:0] RT_CNT_OFS    = 8'h08;
  localparam logic [7:0] RT_COR_OFS    = 8'h0c;
  localparam logic [7:0] RF_STAT_OFS   = 8'h10;

  // ********************************
  // memory control field positions
  // ********************************
  localparam int BANK_ACTIVE_BIT = 9;
  localparam int ADDR_MUX_BIT2_BIT        = 7;
  localparam int SIZE_BIT        = 6;
  localparam int ADDR_MUX_BIT1_BIT        = 5;
  localparam int ADDR_MUX_BIT0_BIT        = 4;
  localparam int REFRESH_ENABLE_BIT        = 3;
  localparam int REFRESH_MODE_SELECT_BIT       = 2;

  // ********************************
  // timer control field positions
  // ********************************
  localparam int CMF_BIT         = 7;
  localparam int MATCH_INTERRUPT_ENABLE_BIT        = 6;
  localparam int CKS_LSB         = 3;
  localparam int RRC_LSB         = 0;

  // ********************************
  // reset values
  // ********************************
  localparam logic [15:0] MEM_CTRL_RST = 16'h0000;
  localparam logic [7:0]  RT_CSR_RST   = 8'h00;
  localparam logic [7:0]  RT_CNT_RST   = 8'h00;
  localparam logic [7:0]  RT_COR_RST   = 8'h00;

  // ********************************
  // prescaler and counts
  // ********************************
  localparam int PRESC_W = 12;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [3:0] COL_BITS_BASE = 4'h8;
  localparam logic [2:0] SDRAM_ORG_RSVD = 3'h6;
  localparam logic [2:0] RRC_MAX_CODE  = 3'h4;

  typedef enum logic [1:0] {
    RF_IDLE,
    RF_BURST,
    RF_SELF
  } rf_state_t;

endpackage

`default_nettype wire

// file: verilog/dram_refresh_ctrl.sv
// dram refresh timer, refresh sequencing and bank mode control
// ********************************
// ********************************
`default_nettype none

module dram_refresh_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // memory side, same clock
  input  wire logic        mem_is_sdram,
  input  wire logic        access_busy,
  input  wire logic        sdram_access_busy,
  input  wire logic        area3_sel,
  input  wire logic        refresh_ack,
  output logic             refresh_req,
  output logic             self_refresh,
  output logic             row_strobe_hold,
  output logic             auto_precharge,
  output logic [3:0]       col_addr_bits,
  output logic [2:0]       sdram_org,
  output logic             mux_reserved,
  output logic             bus_width_32,
  output logic [15:0]      mem_ctrl_value,
  output logic             match_irq
);

  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic [15:0]                    mem_ctrl;
    logic [7:0]                     csr;
    logic                           clr_armed;
    logic [7:0]                     cnt;
    logic [7:0]                     cor;
    logic [dram_refresh_pkg::PRESC_W-1:0] presc;
    dram_refresh_pkg::rf_state_t    st;
    logic [3:0]                     left;
    logic                           pend;
    logic [31:0]                    rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ********************************
  // decode helpers
  // ********************************
  logic        acc_ph;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit;
  logic        tick;
  logic [2:0]  cks;
  logic [2:0]  rrc;
  logic [3:0]  burst_len;
  logic [dram_refresh_pkg::PRESC_W-1:0] tap_mask;
  logic        match;
  logic        refresh_enable_on;
  logic        refresh_mode_select_on;
  logic        bank_mode;
  logic [2:0]  amx;
  logic [31:0] rd_mux;

  assign acc_ph = psel & penable;
  assign wr_acc = acc_ph & pwrite;
  assign rd_acc = acc_ph & ~pwrite;

  always_comb begin
    hit = 1'b1;
    case (paddr)
      dram_refresh_pkg::MEM_CTRL_OFS: hit = 1'b1;
      dram_refresh_pkg::RT_CSR_OFS:   hit = 1'b1;
      dram_refresh_pkg::RT_CNT_OFS:   hit = 1'b1;
      dram_refresh_pkg::RT_COR_OFS:   hit = 1'b1;
      dram_refresh_pkg::RF_STAT_OFS:  hit = 1'b1;
      default:                        hit = 1'b0;
    endcase
  end

  assign cks = s_r.csr[dram_refresh_pkg::CKS_LSB +: 3];
  assign rrc = s_r.csr[dram_refresh_pkg::RRC_LSB +: 3];
  assign refresh_enable_on  = s_r.mem_ctrl[dram_refresh_pkg::REFRESH_ENABLE_BIT];
  assign refresh_mode_select_on = s_r.mem_ctrl[dram_refresh_pkg::REFRESH_MODE_SELECT_BIT];
  assign bank_mode = s_r.mem_ctrl[dram_refresh_pkg::BANK_ACTIVE_BIT];
  assign amx = {s_r.mem_ctrl[dram_refresh_pkg::ADDR_MUX_BIT2_BIT],
                s_r.mem_ctrl[dram_refresh_pkg::ADDR_MUX_BIT1_BIT],
                s_r.mem_ctrl[dram_refresh_pkg::ADDR_MUX_BIT0_BIT]};

  // ********************************
  // prescaler tap selection
  // ********************************
  always_comb begin
    tap_mask = '0;
    case (cks)
      3'h1:    tap_mask = 12'h003;
      3'h2:    tap_mask = 12'h00f;
      3'h3:    tap_mask = 12'h03f;
      3'h4:    tap_mask = 12'h0ff;
      3'h5:    tap_mask = 12'h3ff;
      3'h6:    tap_mask = 12'h7ff;
      3'h7:    tap_mask = 12'hfff;
      default: tap_mask = '0;
    endcase
  end

  // one-cycle enable every 2^n clocks; select zero never ticks
  // the prescaler runs from reset and is never cleared, so the
  // first tick after a select change may come early by up to
  // one divided period
  assign tick = (cks != 3'h0) && ((s_r.presc & tap_mask) == tap_mask);

  // compare is qualified by the count tick so a constant of zero
  // does not hold the flag set on every cycle
  assign match = tick && (s_r.cnt == s_r.cor);

  // ********************************
  // refresh burst length
  // ********************************
  always_comb begin
    burst_len = 4'h1;
    case (rrc)
      3'h0:    burst_len = 4'h1;
      3'h1:    burst_len = 4'h2;
      3'h2:    burst_len = 4'h4;
      3'h3:    burst_len = 4'h6;
      3'h4:    burst_len = 4'h8;
      // reserved codes fall back to a single refresh
      default: burst_len = 4'h1;
    endcase
  end

  // ********************************
  // read mux
  // ********************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      dram_refresh_pkg::MEM_CTRL_OFS:
        rd_mux = {16'h0000, s_r.mem_ctrl};
      dram_refresh_pkg::RT_CSR_OFS:
        rd_mux = {24'h00_0000, s_r.csr};
      dram_refresh_pkg::RT_CNT_OFS:
        rd_mux = {24'h00_0000, s_r.cnt};
      dram_refresh_pkg::RT_COR_OFS:
        rd_mux = {24'h00_0000, s_r.cor};
      dram_refresh_pkg::RF_STAT_OFS:
        rd_mux = {24'h00_0000, s_r.left, 1'b0, s_r.pend,
                  (s_r.st == dram_refresh_pkg::RF_SELF),
                  (s_r.st == dram_refresh_pkg::RF_BURST)};
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // ********************************
  // next state
  // ********************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.presc = s_r.presc + 1'b1;

    // read data is captured in the setup cycle so it stands
    // registered through the access phase
    if (psel && !penable && !pwrite) begin
      s_nxt.rdata = rd_mux;
    end

    // ---- refresh counter ----
    if (tick) begin
      if (match) begin
        s_nxt.cnt = 8'h00;
      end else if (s_r.cnt == dram_refresh_pkg::CNT_MAX) begin
        s_nxt.cnt = 8'h00;
      end else begin
        s_nxt.cnt = s_r.cnt + 8'h01;
      end
    end

    // ---- memory control ----
    if (wr_acc && paddr == dram_refresh_pkg::MEM_CTRL_OFS) begin
      s_nxt.mem_ctrl = pwdata[15:0];
    end

    // ---- counter and constant writes; software write beats tick ----
    if (wr_acc && paddr == dram_refresh_pkg::RT_CNT_OFS) begin
      s_nxt.cnt = pwdata[7:0];
    end
    if (wr_acc && paddr == dram_refresh_pkg::RT_COR_OFS) begin
      s_nxt.cor = pwdata[7:0];
    end

    // ---- timer control and match flag ----
    if (rd_acc && paddr == dram_refresh_pkg::RT_CSR_OFS
        && s_r.csr[dram_refresh_pkg::CMF_BIT]) begin
      s_nxt.clr_armed = 1'b1;
    end
    if (wr_acc && paddr == dram_refresh_pkg::RT_CSR_OFS) begin
      // upper bits are not stored at all
      s_nxt.csr[6:0] = pwdata[6:0];
      if (!pwdata[dram_refresh_pkg::CMF_BIT] && s_r.clr_armed) begin
        s_nxt.csr[dram_refresh_pkg::CMF_BIT] = 1'b0;
        s_nxt.clr_armed = 1'b0;
      end
    end
    // a match in the clearing cycle keeps the flag set
    if (match) begin
      s_nxt.csr[dram_refresh_pkg::CMF_BIT] = 1'b1;
    end
    if (!s_nxt.csr[dram_refresh_pkg::CMF_BIT]) begin
      s_nxt.clr_armed = 1'b0;
    end

    // ---- refresh sequencing ----
    // clearing the enable bit abandons a burst part way through;
    // the memory keeps whatever rows it had refreshed so far
    // a match during a burst restarts the count instead of adding
    // to it, so a slow memory never builds up a backlog
    case (s_r.st)
      dram_refresh_pkg::RF_IDLE: begin
        if (!refresh_enable_on) begin
          s_nxt.pend = 1'b0;
        end else if (refresh_mode_select_on) begin
          // entry waits only for a running sdram access
          s_nxt.pend = 1'b0;
          if (!sdram_access_busy) begin
            s_nxt.st = dram_refresh_pkg::RF_SELF;
          end
        end else if (match) begin
          // a new match replaces anything still unserved
          s_nxt.pend = 1'b1;
          s_nxt.left = burst_len;
          s_nxt.st = dram_refresh_pkg::RF_BURST;
        end
      end
      dram_refresh_pkg::RF_BURST: begin
        if (!refresh_enable_on) begin
          s_nxt.pend = 1'b0;
          s_nxt.left = 4'h0;
          s_nxt.st = dram_refresh_pkg::RF_IDLE;
        end else if (match) begin
          s_nxt.left = burst_len;
        end else if (refresh_ack && refresh_req) begin
          s_nxt.left = s_r.left - 4'h1;
          if (s_r.left == 4'h1) begin
            s_nxt.pend = 1'b0;
            s_nxt.st = dram_refresh_pkg::RF_IDLE;
          end
        end
        // self mode requested mid burst: drop the rest only while no request is out and no sdram access runs
        if (refresh_enable_on && refresh_mode_select_on && !sdram_access_busy
            && !refresh_req) begin
          s_nxt.pend = 1'b0;
          s_nxt.left = 4'h0;
          s_nxt.st = dram_refresh_pkg::RF_SELF;
        end
      end
      dram_refresh_pkg::RF_SELF: begin
        // timer matches still set the flag but start nothing
        s_nxt.pend = 1'b0;
        s_nxt.left = 4'h0;
        if (!refresh_enable_on || !refresh_mode_select_on) begin
          s_nxt.st = dram_refresh_pkg::RF_IDLE;
        end
      end
      default: begin
        s_nxt.st = dram_refresh_pkg::RF_IDLE;
        s_nxt.pend = 1'b0;
      end
    endcase
  end

  // ********************************
  // state register
  // ********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r.mem_ctrl  <= dram_refresh_pkg::MEM_CTRL_RST;
      s_r.csr       <= dram_refresh_pkg::RT_CSR_RST;
      s_r.clr_armed <= 1'b0;
      s_r.cnt       <= dram_refresh_pkg::RT_CNT_RST;
      s_r.cor       <= dram_refresh_pkg::RT_COR_RST;
      s_r.presc     <= '0;
      s_r.st        <= dram_refresh_pkg::RF_IDLE;
      s_r.left      <= 4'h0;
      s_r.pend      <= 1'b0;
      s_r.rdata     <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************************
  // apb answer: zero wait states
  // ********************************
  // every register is a flop or a small mux, so extra wait
  // states would buy nothing
  // read data is taken at setup: a register that changes in the
  // access cycle reads its value from one cycle earlier
  // unmapped addresses answer with an error, never a stall
  assign pready  = 1'b1;
  assign pslverr = acc_ph & ~hit;
  assign prdata  = s_r.rdata;

  // ********************************
  // memory side outputs
  // ********************************
  // the request drops during a running access and returns after it
  assign refresh_req = s_r.pend && (s_r.st == dram_refresh_pkg::RF_BURST)
                       && refresh_enable_on && !access_busy;
  assign self_refresh = (s_r.st == dram_refresh_pkg::RF_SELF);

  // dram: strobe held only in bank mode
  assign row_strobe_hold = !mem_is_sdram && bank_mode;

  // sdram: bank left open only for area 3 in bank mode
  assign auto_precharge = mem_is_sdram
                          && !(bank_mode && area3_sel);

  // dram column width is 8 plus the two low mux bits
  assign col_addr_bits = dram_refresh_pkg::COL_BITS_BASE
                         + {2'b00, amx[1:0]};
  assign sdram_org = amx;

  // x8 and x4 organisations are illegal on a 16-bit bus;
  // flagged for the bus controller, not corrected here
  assign mux_reserved = mem_is_sdram
    ? ((amx == dram_refresh_pkg::SDRAM_ORG_RSVD)
       || (!bus_width_32 && (amx == 3'h1 || amx == 3'h2
                             || amx == 3'h5)))
    : amx[2];

  assign bus_width_32 = s_r.mem_ctrl[dram_refresh_pkg::SIZE_BIT];
  assign mem_ctrl_value = s_r.mem_ctrl;

  // level until software clears the flag
  assign match_irq = s_r.csr[dram_refresh_pkg::CMF_BIT]
                     && s_r.csr[dram_refresh_pkg::MATCH_INTERRUPT_ENABLE_BIT];

endmodule

`default_nettype wire

// file: test/dram_refresh_props.sv
// port assertions for the dram refresh controller
`default_nettype none
module dram_refresh_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        mem_is_sdram,
  input wire logic        access_busy,
  input wire logic        sdram_access_busy,
  input wire logic        area3_sel,
  input wire logic        refresh_req,
  input wire logic        self_refresh,
  input wire logic        row_strobe_hold,
  input wire logic        auto_precharge,
  input wire logic [3:0]  col_addr_bits,
  input wire logic [2:0]  sdram_org,
  input wire logic        bus_width_32,
  input wire logic [15:0] mem_ctrl_value,
  input wire logic        match_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ********************************
  // sequences and properties
  // ********************************
  // exit is registered, so the bits must be off for two edges
  sequence s_self_off;
    !(mem_ctrl_value[3] && mem_ctrl_value[2]) ##1 !(mem_ctrl_value[3] && mem_ctrl_value[2]);
  endsequence
  a_width_size: assert property (bus_width_32 == mem_ctrl_value[6])
    else $error("bus width differs from size bit");
  a_col_width: assert property (!mem_is_sdram |-> col_addr_bits == 4'h8 + mem_ctrl_value[5:4])
    else $error("column width wrong");
  a_org_bits: assert property (sdram_org == {mem_ctrl_value[7], mem_ctrl_value[5:4]})
    else $error("organisation code wrong");
  a_row_hold: assert property (!mem_is_sdram |-> row_strobe_hold == mem_ctrl_value[9])
    else $error("row strobe hold wrong");
  a_auto_pre: assert property (mem_is_sdram |-> auto_precharge == !(mem_ctrl_value[9] && area3_sel))
    else $error("auto precharge wrong");
  a_refresh_off: assert property (!mem_ctrl_value[3] && !$past(mem_ctrl_value[3]) |-> !refresh_req)
    else $error("refresh while disabled");
  a_busy_defer: assert property (access_busy |-> !refresh_req)
    else $error("refresh during access");
  a_self_quiet: assert property (self_refresh |-> !refresh_req)
    else $error("refresh request in self refresh");
  a_self_entry: assert property ($rose(self_refresh) |-> !$past(sdram_access_busy))
    else $error("self refresh entered mid access");
  a_self_exit: assert property (s_self_off |-> !self_refresh)
    else $error("self refresh not left");
  a_irq_hold: assert property (match_irq && !(psel && penable && pwrite) |=> match_irq)
    else $error("interrupt dropped without write");
endmodule
bind dram_refresh_ctrl dram_refresh_props u_props (.*);
`default_nettype wire

// file: test/mem_partner.sv
// memory side model: access windows and refresh acknowledge
`default_nettype none
module mem_partner (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic mem_is_sdram,
  input  wire logic go,
  input  wire logic slow,
  input  wire logic refresh_req,
  output logic      access_busy,
  output logic      sdram_access_busy,
  output logic      refresh_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] busy_cnt;
  logic [1:0] gap;
  assign access_busy = busy_cnt != 4'h0;
  assign sdram_access_busy = access_busy && mem_is_sdram;
  // ********************************
  // access and refresh timing
  // ********************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt <= 4'h0;
      gap <= 2'h0;
      refresh_ack <= 1'b0;
    end else begin
      busy_cnt <= go ? 4'h6 : busy_cnt - {3'h0, access_busy};
      // no refresh mid access; a slow part also idles between refreshes
      refresh_ack <= refresh_req && !refresh_ack && !access_busy && gap == 2'h0;
      gap <= refresh_ack ? {slow, slow} : gap - {1'b0, gap != 2'h0};
    end
  end
endmodule
`default_nettype wire

// file: test/dram_refresh_and_bank_control_test.sv
// self-checking bench for the dram refresh controller
`default_nettype none
module dram_refresh_and_bank_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, mem_is_sdram, area3_sel;
  logic        access_busy, sdram_access_busy, refresh_ack, refresh_req, self_refresh;
  logic        row_strobe_hold, auto_precharge, mux_reserved, bus_width_32, match_irq;
  logic        go, slow, sz, bank, rsv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, w;
  logic [3:0]  col_addr_bits;
  logic [2:0]  sdram_org;
  logic [15:0] mem_ctrl_value;
  logic [32:0] expq[$];
  integer      seed;
  int          errors, tests_run, cycles, i, n;
  dram_refresh_ctrl u_dut (.*);
  mem_partner u_mem (.*);
  // ********************************
  // shared tasks
  // ********************************
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) expq.push_back(exp);
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // read data arrives in the access phase; oldest note is the one due
  always @(posedge clk)
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, expq.pop_front());
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("Error at %0t: timeout", $time);
      end_sim();
    end
  end
  // ********************************
  // main sequence
  // ********************************
  initial begin
    seed = 32'hced95550;
    {errors, tests_run, cycles} = 0;
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {mem_is_sdram, area3_sel, go, slow} = 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 5; i++) rd(8'(i * 4), 33'h0);
    rd(8'h14, {1'b1, 32'h0});
    done("reset");
    for (i = 0; i < 16; i++) begin
      sz = $random(seed);
      bank = $random(seed);
      mem_is_sdram <= i[3];
      area3_sel <= $random(seed);
      w = {22'h0, bank, 1'b0, i[2], sz, i[1:0], 4'h0};
      wr(dram_refresh_pkg::MEM_CTRL_OFS, w);
      rd(dram_refresh_pkg::MEM_CTRL_OFS, {1'b0, w});
      @(negedge clk);
      rsv = i[3] ? (i[2:0] == 6 || (!sz && (i[2:0] == 1 || i[2:0] == 2 || i[2:0] == 5))) : i[2];
      check(mux_reserved, rsv);
      check(bus_width_32, sz);
      check(sdram_org, i[2:0]);
      check(auto_precharge, i[3] && !(bank && area3_sel));
      if (!i[3]) check({row_strobe_hold, col_addr_bits}, {bank, 4'h8 + i[1:0]});
    end
    done("memory control");
    wr(dram_refresh_pkg::MEM_CTRL_OFS, 32'h0);
    wr(dram_refresh_pkg::RT_CSR_OFS, 32'hc7);
    rd(dram_refresh_pkg::RT_CSR_OFS, 33'h47);
    wr(dram_refresh_pkg::RT_CNT_OFS, 32'hfe);
    repeat (50) @(posedge clk);
    rd(dram_refresh_pkg::RT_CNT_OFS, 33'hfe);
    done("timer registers");
    wr(dram_refresh_pkg::RT_COR_OFS, 32'h20);
    for (i = 0; i < 5; i++) begin
      slow <= $random(seed);
      wr(dram_refresh_pkg::RT_CSR_OFS, 32'h8 | i);
      wr(dram_refresh_pkg::MEM_CTRL_OFS, 32'h8);
      n = 0;
      while (refresh_req !== 1'b1) @(posedge clk);
      go <= i == 3;
      while (refresh_req === 1'b1 || access_busy === 1'b1) begin
        @(posedge clk);
        go <= 1'b0;
        if (refresh_req && refresh_ack) n++;
      end
      check(n, (i == 0) ? 1 : 2 * i);
      wr(dram_refresh_pkg::MEM_CTRL_OFS, 32'h0);
    end
    done("refresh burst");
    mem_is_sdram <= 1'b1;
    go <= 1'b1;
    wr(dram_refresh_pkg::MEM_CTRL_OFS, 32'h8);
    go <= 1'b0;
    wr(dram_refresh_pkg::MEM_CTRL_OFS, 32'hc);
    repeat (200) @(posedge clk);
    check(self_refresh, 1'b1);
    rd(dram_refresh_pkg::RF_STAT_OFS, 33'h2);
    wr(dram_refresh_pkg::MEM_CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk);
    check(self_refresh, 1'b0);
    done("self refresh");
    wr(dram_refresh_pkg::RT_COR_OFS, 32'h3);
    wr(dram_refresh_pkg::RT_CSR_OFS, 32'h8);
    repeat (40) @(posedge clk);
    check(match_irq, 1'b0);
    wr(dram_refresh_pkg::RT_CSR_OFS, 32'h40);
    rd(dram_refresh_pkg::RT_CSR_OFS, 33'hc0);
    @(negedge clk);
    check(match_irq, 1'b1);
    wr(dram_refresh_pkg::RT_CSR_OFS, 32'h40);
    rd(dram_refresh_pkg::RT_CSR_OFS, 33'h40);
    check(match_irq, 1'b0);
    done("match flag");
    end_sim();
  end
endmodule
`default_nettype wire
